//--- inc/pif_pkg.sv
package pif_pkg;

    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam logic [7:0] PIF_FLAGS_OFFSET   = 8'h0c;
    localparam logic [7:0] PIF_ENABLES_OFFSET = 8'h8c;
    localparam logic [7:0] PIF_CORE_OFFSET    = 8'h90;
    localparam logic [7:0] PIF_STATUS_OFFSET  = 8'h94;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] PIF_FLAGS_RESET   = 8'h00;
    localparam logic [7:0] PIF_ENABLES_RESET = 8'h00;
    localparam logic [7:0] PIF_CORE_RESET    = 8'h00;

    // ****************************************************************
    // Flag and enable bit positions (same layout in both registers)
    // ****************************************************************
    localparam int PIF_OVERFLOW_BIT    = 0;
    localparam int PIF_CAPTURE_BIT     = 1;
    localparam int PIF_PORT_CHANGE_BIT = 2;
    localparam int PIF_SERIAL_BIT      = 3;
    localparam int PIF_PUSHBUTTON_BIT  = 4;
    localparam int PIF_COMPARATOR_BIT  = 7;
    // Bits 6 and 5 unimplemented
    localparam logic [7:0] PIF_SOURCE_MASK = 8'h9f;

    // ****************************************************************
    // Core interrupt control bits
    // ****************************************************************
    localparam int PIF_GLOBAL_ENABLE_BIT = 7;
    localparam int PIF_GROUP_ENABLE_BIT  = 6;
    localparam int PIF_HS_MODE_BIT       = 0;
    localparam logic [7:0] PIF_CORE_MASK = 8'hc1;

    // ****************************************************************
    // Status register fields
    // ****************************************************************
    localparam int PIF_STAT_IRQ_BIT        = 0;
    localparam int PIF_STAT_PUSHBUTTON_BIT = 1;
    localparam int PIF_STAT_COMPARATOR_BIT = 2;
    localparam int PIF_STAT_PORT_LSB       = 4;

    // ****************************************************************
    // Pin synchroniser vector layout
    // ****************************************************************
    localparam int PIF_SYNC_WIDTH      = 6;
    localparam int PIF_SYNC_PORT_LSB   = 0;
    localparam int PIF_SYNC_PUSHBUTTON = 4;
    localparam int PIF_SYNC_COMPARATOR = 5;

    // ****************************************************************
    // AXI4-Lite responses
    // ****************************************************************
    localparam logic [1:0] PIF_RESP_OKAY   = 2'b00;
    localparam logic [1:0] PIF_RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        PIF_WR_COLLECT = 2'b01,
        PIF_WR_RESPOND = 2'b10
    } pif_wr_state_type;

endpackage

//--- hw/pif_pin_sync.sv
`timescale 1ns/1ps
module pif_pin_sync
    import pif_pkg::*;
#(
    parameter int WIDTH = PIF_SYNC_WIDTH
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level_out,
    output logic      [WIDTH-1:0] change_out
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic             primed;
    logic [2:0]       filled;

    // ****************************************************************
    // Three-stage capture
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            filled <= 3'b000;
        end else begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
            // Marks stages that hold real pin samples
            filled <= {filled[1:0], 1'b1};
        end
    end

    // ****************************************************************
    // Accept a level once stages two and three agree
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            primed     <= 1'b0;
            level_out  <= '0;
            change_out <= '0;
        end else begin
            change_out <= '0;
            if (!primed) begin
                // First settled sample loads without reporting a change;
                // before three edges the stages still hold reset zeros
                if (filled[2] && (stage2 == stage3)) begin
                    primed    <= 1'b1;
                    level_out <= stage3;
                end
            end else begin
                for (int i = 0; i < WIDTH; i++) begin
                    if ((stage2[i] == stage3[i]) && (stage3[i] != level_out[i])) begin
                        level_out[i]  <= stage3[i];
                        change_out[i] <= 1'b1;
                    end
                end
            end
        end
    end

endmodule // pif_pin_sync

//--- hw/pif_peripheral_irq.sv
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
// How it works
// - Flags set regardless of any enable
// - Global enable clear blocks requests, flags still captured
// - Group enable bit 6 gates every source
// - Overflow sets flag, held; enable permits
// - Capture sets flag, held; enable permits
// - Upper port C change sets flag
// - Serial completion sets flag; software clears it
// - Pushbutton flag; unavailable in high-speed mode
// - Comparator trip flag, level sensitive
// - Enable bits 6,5 read zero; 7 comparator
// - Enables at 0x8c, flags at 0x0c, reset zero
module pif_peripheral_irq
    import pif_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        counter_overflow_event,
    input  wire logic        capture_event,
    input  wire logic        serial_done_event,
    input  wire logic [3:0]  port_c_a_upper,
    input  wire logic        oscillator_pushbutton_pin,
    input  wire logic        comparator_trip_pin,
    output logic             peripheral_irq
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [7:0]                peripheral_irq_flags;
    logic [7:0]                peripheral_irq_enables;
    logic [7:0]                core_interrupt_control;
    logic [7:0]                next_flags;
    logic [7:0]                set_vector;
    logic [7:0]                pending;
    logic [7:0]                status_word;
    logic [7:0]                read_byte;
    logic                      read_hit;
    pif_wr_state_type          wr_state;
    logic                      aw_held;
    logic                      w_held;
    logic [7:0]                aw_addr_q;
    logic [7:0]                w_data_q;
    logic                      w_lane_q;
    logic                      wr_commit;
    logic                      wr_hit;
    logic                      wr_flags;
    logic                      wr_enables;
    logic                      wr_core;
    logic                      hs_mode;
    logic [PIF_SYNC_WIDTH-1:0] pin_vector;
    logic [PIF_SYNC_WIDTH-1:0] pin_level;
    logic [PIF_SYNC_WIDTH-1:0] pin_change;

    function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] offset);
        addr_is = (addr[7:2] == offset[7:2]);
    endfunction

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    assign pin_vector = {comparator_trip_pin, oscillator_pushbutton_pin, port_c_a_upper};

    pif_pin_sync #(
        .WIDTH (PIF_SYNC_WIDTH)
    ) u_pin_sync (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .pin_in     (pin_vector),
        .level_out  (pin_level),
        .change_out (pin_change)
    );

    assign hs_mode = core_interrupt_control[PIF_HS_MODE_BIT];

    // ****************************************************************
    // Event capture
    // ****************************************************************
    always_comb begin
        set_vector = 8'h00;
        set_vector[PIF_OVERFLOW_BIT] = counter_overflow_event;
        set_vector[PIF_CAPTURE_BIT]  = capture_event;
        set_vector[PIF_PORT_CHANGE_BIT] =
            |pin_change[PIF_SYNC_PORT_LSB +: 4];
        set_vector[PIF_SERIAL_BIT] = serial_done_event;
        // Press pulls the shared oscillator pin low
        set_vector[PIF_PUSHBUTTON_BIT] = pin_change[PIF_SYNC_PUSHBUTTON]
            & ~pin_level[PIF_SYNC_PUSHBUTTON] & ~hs_mode;
        // Re-asserted every cycle while the comparator stays tripped
        set_vector[PIF_COMPARATOR_BIT] = pin_level[PIF_SYNC_COMPARATOR];
    end

    always_comb begin
        next_flags = peripheral_irq_flags;
        if (wr_flags) begin
            next_flags = w_data_q & PIF_SOURCE_MASK;
        end
        // Hardware set wins over a software clear, enables not consulted
        next_flags = next_flags | set_vector;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            peripheral_irq_flags <= PIF_FLAGS_RESET;
        end else begin
            peripheral_irq_flags <= next_flags;
        end
    end

    // ****************************************************************
    // Enable and core control registers
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            peripheral_irq_enables <= PIF_ENABLES_RESET;
        end else if (wr_enables) begin
            peripheral_irq_enables <= w_data_q & PIF_SOURCE_MASK;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_interrupt_control <= PIF_CORE_RESET;
        end else if (wr_core) begin
            core_interrupt_control <= w_data_q & PIF_CORE_MASK;
        end
    end

    // ****************************************************************
    // Interrupt request
    // ****************************************************************
    always_comb begin
        pending = peripheral_irq_flags & peripheral_irq_enables;
        // Pushbutton source is dead in high-speed crystal mode
        pending[PIF_PUSHBUTTON_BIT] = pending[PIF_PUSHBUTTON_BIT] & ~hs_mode;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            peripheral_irq <= 1'b0;
        end else begin
            peripheral_irq <= (|pending)
                & core_interrupt_control[PIF_GROUP_ENABLE_BIT]
                & core_interrupt_control[PIF_GLOBAL_ENABLE_BIT];
        end
    end

    // ****************************************************************
    // AXI4-Lite write channel
    // ****************************************************************
    assign wr_commit  = (wr_state == PIF_WR_COLLECT) && aw_held && w_held;
    assign wr_hit     = addr_is(aw_addr_q, PIF_FLAGS_OFFSET)
                        || addr_is(aw_addr_q, PIF_ENABLES_OFFSET)
                        || addr_is(aw_addr_q, PIF_CORE_OFFSET)
                        || addr_is(aw_addr_q, PIF_STATUS_OFFSET);
    assign wr_flags   = wr_commit && w_lane_q && addr_is(aw_addr_q, PIF_FLAGS_OFFSET);
    assign wr_enables = wr_commit && w_lane_q && addr_is(aw_addr_q, PIF_ENABLES_OFFSET);
    assign wr_core    = wr_commit && w_lane_q && addr_is(aw_addr_q, PIF_CORE_OFFSET);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            aw_addr_q     <= 8'h00;
            s_axi_awready <= 1'b1;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held       <= 1'b1;
            aw_addr_q     <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (wr_commit) begin
            aw_held <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held       <= 1'b0;
            w_data_q     <= 8'h00;
            w_lane_q     <= 1'b0;
            s_axi_wready <= 1'b1;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held       <= 1'b1;
            w_data_q     <= s_axi_wdata[7:0];
            w_lane_q     <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
        end else if (wr_commit) begin
            w_held <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state     <= PIF_WR_COLLECT;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= PIF_RESP_OKAY;
        end else begin
            case (wr_state)
                PIF_WR_COLLECT: begin
                    if (wr_commit) begin
                        wr_state     <= PIF_WR_RESPOND;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp  <= wr_hit ? PIF_RESP_OKAY : PIF_RESP_SLVERR;
                    end
                end
                PIF_WR_RESPOND: begin
                    if (s_axi_bready) begin
                        wr_state     <= PIF_WR_COLLECT;
                        s_axi_bvalid <= 1'b0;
                    end
                end
                default: begin
                    wr_state     <= PIF_WR_COLLECT;
                    s_axi_bvalid <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************************************
    // AXI4-Lite read channel
    // ****************************************************************
    always_comb begin
        status_word = 8'h00;
        status_word[PIF_STAT_IRQ_BIT]        = peripheral_irq;
        status_word[PIF_STAT_PUSHBUTTON_BIT] = pin_level[PIF_SYNC_PUSHBUTTON];
        status_word[PIF_STAT_COMPARATOR_BIT] = pin_level[PIF_SYNC_COMPARATOR];
        status_word[PIF_STAT_PORT_LSB +: 4]  = pin_level[PIF_SYNC_PORT_LSB +: 4];
    end

    always_comb begin
        read_byte = 8'h00;
        read_hit  = 1'b1;
        if (addr_is(s_axi_araddr, PIF_FLAGS_OFFSET)) begin
            read_byte = peripheral_irq_flags;
        end else if (addr_is(s_axi_araddr, PIF_ENABLES_OFFSET)) begin
            read_byte = peripheral_irq_enables;
        end else if (addr_is(s_axi_araddr, PIF_CORE_OFFSET)) begin
            read_byte = core_interrupt_control;
        end else if (addr_is(s_axi_araddr, PIF_STATUS_OFFSET)) begin
            read_byte = status_word;
        end else begin
            read_hit = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= PIF_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {24'h00_0000, read_byte};
            s_axi_rresp   <= read_hit ? PIF_RESP_OKAY : PIF_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
        end
    end

endmodule // pif_peripheral_irq

//--- tb/pif_peripheral_irq_props.sv
`timescale 1ns/1ps
module pif_peripheral_irq_props
    import pif_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        peripheral_irq
);
    // ****
    // Address of the read in flight
    // ****
    logic [7:0] rd_addr;
    logic       rd_ctl;
    logic       rd_mapped;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_addr <= 8'h00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rd_addr <= s_axi_araddr;
        end
    end
    assign rd_ctl = (rd_addr[7:2] == PIF_FLAGS_OFFSET[7:2])
                  || (rd_addr[7:2] == PIF_ENABLES_OFFSET[7:2]);
    assign rd_mapped = rd_ctl || (rd_addr[7:2] == PIF_CORE_OFFSET[7:2])
                     || (rd_addr[7:2] == PIF_STATUS_OFFSET[7:2]);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_reset_idle;
        $rose(aresetn) |-> !peripheral_irq && s_axi_awready && s_axi_arready && !s_axi_bvalid;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");
    property p_aw_refuse;
        s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
    endproperty
    a_aw_refuse: assert property (p_aw_refuse) else $error("awready high after take");
    property p_b_latency;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |=> !s_axi_bvalid ##1 s_axi_bvalid;
    endproperty
    a_b_latency: assert property (p_b_latency) else $error("write answer late");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_b_release;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
    endproperty
    a_b_release: assert property (p_b_release) else $error("write channel not reopened");
    property p_ar_take;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_ar_take: assert property (p_ar_take) else $error("read answer late");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data not held");
    property p_r_reserved;
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 && (!rd_ctl || s_axi_rdata[6:5] == 2'b00);
    endproperty
    a_r_reserved: assert property (p_r_reserved) else $error("reserved bits set");
    property p_r_unmapped;
        s_axi_rvalid && !rd_mapped |-> s_axi_rresp == PIF_RESP_SLVERR && s_axi_rdata == 32'h0;
    endproperty
    a_r_unmapped: assert property (p_r_unmapped) else $error("unmapped read answered");
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready && rd_ctl);
    c_irq: cover property ($rose(peripheral_irq));
endmodule // pif_peripheral_irq_props

bind pif_peripheral_irq pif_peripheral_irq_props u_props (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .peripheral_irq);

//--- tb/pif_peripheral_irq_bench.sv
`timescale 1ns/1ps
module pif_peripheral_irq_bench
    import pif_pkg::*;
;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [2:0]  s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb, port_c_a_upper;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, peripheral_irq;
    logic        counter_overflow_event, capture_event, serial_done_event;
    logic        oscillator_pushbutton_pin, comparator_trip_pin;
    logic [1:0]  exp_b[$];
    logic [33:0] exp_r[$];
    logic [31:0] rng;
    int          mismatches = 0;
    int          n_tests = 0;
    int          cycles = 0;

    pif_peripheral_irq dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .counter_overflow_event, .capture_event, .serial_done_event, .port_c_a_upper,
        .oscillator_pushbutton_pin, .comparator_trip_pin, .peripheral_irq);

    initial aclk = 1'b0;
    always #2.5 aclk = ~aclk;

    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ****
    // Bus master
    // ****
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
        exp_b.push_back(r);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
        exp_r.push_back({r, 24'h0, d});
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic irq_is(input logic e);
        repeat (2) @(posedge aclk);
        check({33'h0, peripheral_irq}, {33'h0, e});
    endtask

    // ****
    // Result monitor and watchdog
    // ****
    always @(posedge aclk) begin
        if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
            check({32'h0, s_axi_bresp}, {32'h0, exp_b.pop_front()});
        end
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
            check({s_axi_rresp, s_axi_rdata}, exp_r.pop_front());
        end
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            mismatches++;
            complete_run();
        end
    end

    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot} = '0;
        {counter_overflow_event, capture_event, serial_done_event, comparator_trip_pin} = '0;
        s_axi_wstrb = 4'hf;
        rng = 32'hb8666f74;
        port_c_a_upper = rng[3:0];
        oscillator_pushbutton_pin = 1'b1;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(PIF_FLAGS_OFFSET, 8'h00, PIF_RESP_OKAY);
        rd(PIF_ENABLES_OFFSET, 8'h00, PIF_RESP_OKAY);
        rd(8'h40, 8'h00, PIF_RESP_SLVERR);
        wr(8'h40, 8'hff, PIF_RESP_SLVERR);
        for (int i = 0; i < 4; i++) begin
            rng = xs(rng);
            wr(PIF_ENABLES_OFFSET, rng[7:0], PIF_RESP_OKAY);
            rd(PIF_ENABLES_OFFSET, rng[7:0] & PIF_SOURCE_MASK, PIF_RESP_OKAY);
        end
        wr(PIF_ENABLES_OFFSET, 8'h00, PIF_RESP_OKAY);
        // Low byte lane off: write answered but not stored
        s_axi_wstrb <= 4'he;
        wr(PIF_ENABLES_OFFSET, 8'hff, PIF_RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        rd(PIF_ENABLES_OFFSET, 8'h00, PIF_RESP_OKAY);
        {counter_overflow_event, capture_event, serial_done_event} <= 3'b111;
        @(posedge aclk);
        {counter_overflow_event, capture_event, serial_done_event} <= 3'b000;
        @(posedge aclk);
        rd(PIF_FLAGS_OFFSET, 8'h0b, PIF_RESP_OKAY);
        irq_is(1'b0);
        rng = xs(rng);
        port_c_a_upper <= port_c_a_upper ^ (rng[3:0] | 4'h1);
        repeat (8) @(posedge aclk);
        rd(PIF_FLAGS_OFFSET, 8'h0f, PIF_RESP_OKAY);
        oscillator_pushbutton_pin <= 1'b0;
        repeat (8) @(posedge aclk);
        rd(PIF_FLAGS_OFFSET, 8'h1f, PIF_RESP_OKAY);
        comparator_trip_pin <= 1'b1;
        repeat (8) @(posedge aclk);
        wr(PIF_FLAGS_OFFSET, 8'h00, PIF_RESP_OKAY);
        rd(PIF_FLAGS_OFFSET, 8'h80, PIF_RESP_OKAY);
        comparator_trip_pin <= 1'b0;
        oscillator_pushbutton_pin <= 1'b1;
        repeat (8) @(posedge aclk);
        wr(PIF_FLAGS_OFFSET, 8'h00, PIF_RESP_OKAY);
        rd(PIF_FLAGS_OFFSET, 8'h00, PIF_RESP_OKAY);
        wr(PIF_CORE_OFFSET, 8'h01, PIF_RESP_OKAY);
        rd(PIF_CORE_OFFSET, 8'h01, PIF_RESP_OKAY);
        oscillator_pushbutton_pin <= 1'b0;
        repeat (8) @(posedge aclk);
        rd(PIF_FLAGS_OFFSET, 8'h00, PIF_RESP_OKAY);
        rd(PIF_STATUS_OFFSET, {port_c_a_upper, 4'h0}, PIF_RESP_OKAY);
        for (int i = 0; i < 8; i++) begin
            if (PIF_SOURCE_MASK[i]) begin
                wr(PIF_CORE_OFFSET, 8'h00, PIF_RESP_OKAY);
                wr(PIF_FLAGS_OFFSET, 8'h00, PIF_RESP_OKAY);
                wr(PIF_ENABLES_OFFSET, 8'h01 << i, PIF_RESP_OKAY);
                wr(PIF_FLAGS_OFFSET, 8'h01 << i, PIF_RESP_OKAY);
                wr(PIF_CORE_OFFSET, 8'h80, PIF_RESP_OKAY);
                irq_is(1'b0);
                wr(PIF_CORE_OFFSET, 8'h40, PIF_RESP_OKAY);
                irq_is(1'b0);
                wr(PIF_CORE_OFFSET, 8'hc0, PIF_RESP_OKAY);
                irq_is(1'b1);
                if (i == PIF_PUSHBUTTON_BIT) begin
                    wr(PIF_CORE_OFFSET, 8'hc1, PIF_RESP_OKAY);
                    irq_is(1'b0);
                end
                wr(PIF_ENABLES_OFFSET, PIF_SOURCE_MASK & ~(8'h01 << i), PIF_RESP_OKAY);
                irq_is(1'b0);
            end
        end
        // Second reset in mid-run clears every register
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(PIF_FLAGS_OFFSET, 8'h00, PIF_RESP_OKAY);
        rd(PIF_ENABLES_OFFSET, 8'h00, PIF_RESP_OKAY);
        rd(PIF_CORE_OFFSET, 8'h00, PIF_RESP_OKAY);
        irq_is(1'b0);
        complete_run();
    end
endmodule // pif_peripheral_irq_bench
